// File: rtl/chip_select_decoder.sv
// Memory and peripheral chip-select decoder with ready mode output
`timescale 1ns/1ps

// Operation
// - Upper region top fixed at highest address
// - Upper select when address top at/above value
// - Reset leaves upper select at 1K
// - Upper and lower ready from own registers
// - Lower select when address top at/below value
// - Lower select off until its register accessed
// - Mid block split into four quarters
// - Mid base from base bits fifteen to nine
// - Mid selects off until both registers accessed
// - Mid base ready bits serve all quarters
// - Enhanced mode keeps only mid select two
// - Seven peripheral selects, 128-byte windows
// - Peripheral base on 1K boundaries
// - Mode bit clear gives latched A1, A2
// - Space bit picks memory or I/O decode
// - Peripheral selects off until both accessed
// - Peripheral ready split between two registers
// - Upper register loads fffb on reset
// - Ready field: waits plus external-ready choice
// - All selects high during reset
module chip_select_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Mode strap
  input wire logic enhanced_mode,
  // Bus cycle from processor or DMA
  input wire chip_select_pkg::bus_cycle_s cycle,
  // Control block register access
  input wire chip_select_pkg::reg_access_s access,
  output logic [15:0] rdata,
  // Chip selects
  output logic upper_memory_select_n,
  output logic lower_memory_select_n,
  output logic [3:0] midrange_select_n,
  output logic [6:0] peripheral_select_n,
  // Ready mode to wait-state generator
  output chip_select_pkg::ready_mode_t ready_mode_field,
  output logic [1:0] wait_states,
  output logic ignore_external_ready,
  output logic ready_valid
);

  // ********************************
  // Control registers
  // ********************************
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] pbase_q;
  logic [15:0] mbase_q;
  logic [15:0] msize_q;
  logic [4:0] accessed_q;

  wire hit_u = access.valid && access.offset == chip_select_pkg::upper_memory_select_control_off;
  wire hit_l = access.valid && access.offset == chip_select_pkg::lower_memory_select_control_off;
  wire hit_p = access.valid && access.offset == chip_select_pkg::peripheral_select_base_off;
  wire hit_b = access.valid && access.offset == chip_select_pkg::midrange_select_base_off;
  wire hit_s = access.valid && access.offset == chip_select_pkg::midrange_size_and_peripheral_mode_off;
  wire [4:0] hit_vec = {hit_s, hit_b, hit_p, hit_l, hit_u};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      upper_q <= chip_select_pkg::upper_control_reset;
      accessed_q <= 5'h00;
    end else begin
      accessed_q <= accessed_q | hit_vec;
      if (hit_u && access.write) upper_q <= access.wdata;
    end
  end

  // Registers without defined reset content
  always_ff @(posedge core_clk) begin
    if (hit_l && access.write) lower_q <= access.wdata;
    if (hit_p && access.write) pbase_q <= access.wdata;
    if (hit_b && access.write) mbase_q <= access.wdata;
    if (hit_s && access.write) msize_q <= access.wdata;
  end

  wire [15:0] rdata_d = hit_u ? upper_q : hit_l ? lower_q : hit_p ? pbase_q :
                        hit_b ? mbase_q : hit_s ? msize_q : 16'h0000;

  // ********************************
  // Enables from accessed flags
  // ********************************
  wire en_lower = accessed_q[1];
  wire en_mid = accessed_q[3] & accessed_q[4];
  wire en_periph = accessed_q[2] & accessed_q[4];

  // ********************************
  // Memory region decode
  // ********************************
  wire [15:0] a_top = cycle.addr[19:4];
  wire mem_cycle = cycle.valid & cycle.memory_space;
  wire upper_hit = mem_cycle && a_top >= (upper_q & chip_select_pkg::low_six_zeros);
  wire lower_hit = mem_cycle && en_lower && a_top <= (lower_q | chip_select_pkg::low_six_ones);

  // Mid block: one-hot size bit k gives total 8K << k
  wire [6:0] msize = msize_q[chip_select_pkg::mid_size_lsb +: chip_select_pkg::mid_size_width];
  logic [19:0] mid_mask;
  logic [1:0] mid_quarter;
  always_comb begin
    mid_mask = 20'hfe000;
    mid_quarter = cycle.addr[12:11];
    for (int k = 0; k < 7; k++) begin
      if (msize[k]) begin
        mid_mask = 20'hfe000 << k;
        mid_quarter = 2'(cycle.addr >> (11 + k));
      end
    end
  end
  wire [19:0] mid_base = {mbase_q[15:chip_select_pkg::mid_base_lsb], 13'h0000};
  wire mid_hit = mem_cycle && en_mid && ((cycle.addr & mid_mask) == (mid_base & mid_mask));

  // ********************************
  // Peripheral decode
  // ********************************
  wire [19:0] peripheral_block_base = {pbase_q[15:chip_select_pkg::periph_base_lsb], 10'h000};
  wire space_ok = cycle.valid && (cycle.memory_space == msize_q[chip_select_pkg::space_bit]);
  wire seven = msize_q[chip_select_pkg::seven_bit];
  wire [19:0] poff = cycle.addr - peripheral_block_base;
  wire in_block = space_ok && en_periph && cycle.addr >= peripheral_block_base && poff[19:10] == 10'h000;
  wire [2:0] pidx = poff[9:7];
  logic [6:0] periph_hit;

  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_periph
      assign periph_hit[g] = in_block && pidx == 3'(g) && (g < 5 || seven);
    end
  endgenerate

  wire periph_low_hit = |periph_hit[3:0];
  wire periph_high_hit = |periph_hit[6:4];

  // ********************************
  // Ready mode selection
  // ********************************
  chip_select_pkg::ready_mode_t sel_mode;
  logic any_hit;

  ready_mode_select u_ready_mode_select (
    .upper_hit(upper_hit),
    .lower_hit(lower_hit),
    .mid_hit(mid_hit),
    .periph_low_hit(periph_low_hit),
    .periph_high_hit(periph_high_hit),
    .upper_mode(upper_q[2:0]),
    .lower_mode(lower_q[2:0]),
    .mid_mode(mbase_q[2:0]),
    .periph_low_mode(pbase_q[2:0]),
    .periph_high_mode(msize_q[2:0]),
    .mode(sel_mode),
    .any_hit(any_hit)
  );

  // ********************************
  // Select outputs
  // ********************************
  logic [3:0] mid_sel_d;
  always_comb begin
    mid_sel_d = 4'hf;
    if (mid_hit) mid_sel_d[mid_quarter] = 1'b0;
    if (enhanced_mode) mid_sel_d = {1'b1, mid_sel_d[2], 2'b11};
  end

  // Latched A2, A1 hold the last valid cycle's bits between cycles
  logic [1:0] a12_q;
  wire [1:0] addr_bits = cycle.valid ? cycle.addr[2:1] : a12_q;
  logic [6:0] periph_d;
  always_comb begin
    periph_d = ~periph_hit;
    if (en_periph && !seven) periph_d[6:5] = addr_bits;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      upper_memory_select_n <= 1'b1;
      lower_memory_select_n <= 1'b1;
      midrange_select_n <= 4'hf;
      peripheral_select_n <= 7'h7f;
      ready_mode_field <= 3'h0;
      wait_states <= 2'h0;
      ignore_external_ready <= 1'b0;
      ready_valid <= 1'b0;
      rdata <= 16'h0000;
      a12_q <= 2'h0;
    end else begin
      upper_memory_select_n <= ~upper_hit;
      lower_memory_select_n <= ~lower_hit;
      midrange_select_n <= mid_sel_d;
      peripheral_select_n <= periph_d;
      if (cycle.valid) a12_q <= {cycle.addr[2], cycle.addr[1]};
      ready_mode_field <= sel_mode;
      wait_states <= sel_mode[1:0];
      ignore_external_ready <= sel_mode[2];
      ready_valid <= any_hit;
      rdata <= rdata_d;
    end
  end

  // ********************************
  // Checks
  // ********************************
  property p_upper_reset;
    @(posedge core_clk) $rose(reset_n) |-> upper_q == 16'hfffb;
  endproperty
  a_upper_reset: assert property (p_upper_reset) else $error("upper reset value wrong");

  property p_upper_sel;
    @(posedge core_clk) disable iff (!reset_n) mem_cycle && a_top >= {upper_q[15:6], 6'h00} |=> !upper_memory_select_n;
  endproperty
  a_upper_sel: assert property (p_upper_sel) else $error("upper select missed");

  property p_lower_gate;
    @(posedge core_clk) disable iff (!reset_n) !accessed_q[1] |=> lower_memory_select_n;
  endproperty
  a_lower_gate: assert property (p_lower_gate) else $error("lower select before access");

  property p_mid_gate;
    @(posedge core_clk) disable iff (!reset_n) !(accessed_q[3] && accessed_q[4]) |=> &midrange_select_n;
  endproperty
  a_mid_gate: assert property (p_mid_gate) else $error("mid select before access");

  property p_periph_gate;
    @(posedge core_clk) disable iff (!reset_n) !(accessed_q[2] && accessed_q[4]) |=> &peripheral_select_n;
  endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("peripheral select before access");

  property p_enhanced;
    @(posedge core_clk) disable iff (!reset_n) enhanced_mode |=>
      midrange_select_n[0] && midrange_select_n[1] && midrange_select_n[3];
  endproperty
  a_enhanced: assert property (p_enhanced) else $error("enhanced mode mid pins active");

  property p_latched_addr;
    @(posedge core_clk) disable iff (!reset_n) cycle.valid && accessed_q[2] && accessed_q[4] && !msize_q[7] |=>
      peripheral_select_n[6:5] == $past(cycle.addr[2:1]);
  endproperty
  a_latched_addr: assert property (p_latched_addr) else $error("latched address bits wrong");

  property p_reset_high;
    @(posedge core_clk) !reset_n |=> upper_memory_select_n && lower_memory_select_n &&
      &midrange_select_n && &peripheral_select_n;
  endproperty
  a_reset_high: assert property (p_reset_high) else $error("select low after reset");

  property p_wait_split;
    @(posedge core_clk) disable iff (!reset_n) upper_hit |=>
      ready_valid && ready_mode_field == $past(upper_q[2:0]) &&
      wait_states == $past(upper_q[1:0]) && ignore_external_ready == $past(upper_q[2]);
  endproperty
  a_wait_split: assert property (p_wait_split) else $error("ready field split wrong");

endmodule

// File: pkg/chip_select_pkg.sv
// Constants and carrier types for the chip-select decoder
package chip_select_pkg;

  // ********************************
  // Register offsets in the control block
  // ********************************
  localparam logic [7:0] upper_memory_select_control_off = 8'ha0;
  localparam logic [7:0] lower_memory_select_control_off = 8'ha2;
  localparam logic [7:0] peripheral_select_base_off = 8'ha4;
  localparam logic [7:0] midrange_select_base_off = 8'ha6;
  localparam logic [7:0] midrange_size_and_peripheral_mode_off = 8'ha8;

  // ********************************
  // Reset values and field positions
  // ********************************
  localparam logic [15:0] upper_control_reset = 16'hfffb;
  localparam logic [15:0] low_six_ones = 16'h003f;
  localparam logic [15:0] low_six_zeros = 16'hffc0;
  localparam int ready_lsb = 0;
  localparam int space_bit = 6;
  localparam int seven_bit = 7;
  localparam int mid_size_lsb = 8;
  localparam int mid_size_width = 7;
  localparam int mid_base_lsb = 9;
  localparam int periph_base_lsb = 6;
  localparam int periph_window_shift = 7;
  localparam int midrange_count = 4;
  localparam int periph_count = 7;
  localparam int periph_ready_split = 4;

  // ********************************
  // Carrier types
  // ********************************
  typedef struct packed {
    logic valid;
    logic memory_space;
    logic [19:0] addr;
  } bus_cycle_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [15:0] wdata;
  } reg_access_s;

  typedef logic [2:0] ready_mode_t;

endpackage

// File: rtl/ready_mode_select.sv
// Ready mode selection for the active chip-select region
`timescale 1ns/1ps

module ready_mode_select (
  // Per-region hits and modes
  input wire logic upper_hit,
  input wire logic lower_hit,
  input wire logic mid_hit,
  input wire logic periph_low_hit,
  input wire logic periph_high_hit,
  input wire chip_select_pkg::ready_mode_t upper_mode,
  input wire chip_select_pkg::ready_mode_t lower_mode,
  input wire chip_select_pkg::ready_mode_t mid_mode,
  input wire chip_select_pkg::ready_mode_t periph_low_mode,
  input wire chip_select_pkg::ready_mode_t periph_high_mode,
  // Selected mode
  output chip_select_pkg::ready_mode_t mode,
  output logic any_hit
);

  assign any_hit = upper_hit | lower_hit | mid_hit | periph_low_hit | periph_high_hit;
  assign mode = upper_hit ? upper_mode :
                lower_hit ? lower_mode :
                mid_hit ? mid_mode :
                periph_low_hit ? periph_low_mode :
                periph_high_hit ? periph_high_mode : 3'h0;

endmodule

// File: dv/select_partner.sv
// Far-side devices that count the cycles in which they are selected
`timescale 1ns/1ps
module select_partner (
  // Clock
  input wire logic core_clk,
  // Memory selects and peripheral selects 0 to 4
  input wire logic [10:0] sel_n,
  // Selected cycle count
  output int hits
);
  initial hits = 0;
  always @(negedge core_clk) begin
    if (sel_n !== 11'h7ff) begin
      hits = hits + 1;
    end
  end
endmodule

// File: dv/chip_select_decoder_tb.sv
// Self-checking bench for the chip-select decoder
`timescale 1ns/1ps
module chip_select_decoder_tb;
  logic core_clk = 0;
  logic reset_n = 0;
  logic enhanced_mode = 0;
  chip_select_pkg::bus_cycle_s cycle = '0;
  chip_select_pkg::reg_access_s access = '0;
  logic [15:0] rdata;
  logic upper_memory_select_n, lower_memory_select_n, ignore_external_ready, ready_valid;
  logic [3:0] midrange_select_n;
  logic [6:0] peripheral_select_n;
  logic [1:0] wait_states;
  chip_select_pkg::ready_mode_t ready_mode_field;
  int bad_count = 0, checked = 0, seed = 74588, hits, exp_hits = 0, k;
  logic [15:0] regs [6];
  bit acc [6];
  logic [12:0] exp_sel;
  logic [2:0] exp_mode;
  logic exp_rv, sp;
  logic [31:0] r;
  logic [19:0] a;
  wire [12:0] sel_n = {upper_memory_select_n, lower_memory_select_n, midrange_select_n, peripheral_select_n};
  always #10 core_clk = ~core_clk;
  chip_select_decoder u_chip_select_decoder (.core_clk(core_clk), .reset_n(reset_n),
    .enhanced_mode(enhanced_mode), .cycle(cycle), .access(access), .rdata(rdata),
    .upper_memory_select_n(upper_memory_select_n), .lower_memory_select_n(lower_memory_select_n),
    .midrange_select_n(midrange_select_n), .peripheral_select_n(peripheral_select_n),
    .ready_mode_field(ready_mode_field), .wait_states(wait_states),
    .ignore_external_ready(ignore_external_ready), .ready_valid(ready_valid));
  select_partner u_select_partner (.core_clk(core_clk), .sel_n({sel_n[12:7], sel_n[4:0]}), .hits(hits));
  // ********************************
  // Checking and closing
  // ********************************
  task automatic compare(input logic [15:0] seen, input logic [15:0] want, input string what);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask
  task automatic conclude;
    $display("Counts: %0d compared, %0d wrong", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic reg_op(input int idx, input bit wr, input logic [15:0] d);
    @(negedge core_clk);
    access = '{1'b1, wr, chip_select_pkg::upper_memory_select_control_off + 8'(2 * idx), d};
    @(negedge core_clk);
    access = '0;
    if (!wr) compare(rdata, idx < 5 ? regs[idx] : 16'h0000, "read data");
    if (wr && idx < 5) regs[idx] = d;
    acc[idx] = idx < 5;
  endtask
  task automatic take(input logic [2:0] m);
    if (!exp_rv) exp_mode = m;
    exp_rv = 1;
  endtask
  // ********************************
  // Reference model of the decode
  // ********************************
  task automatic predict(input logic [19:0] a, input bit ms);
    int n, tot, base, q;
    exp_sel = 13'h1fff;
    exp_rv = 0;
    exp_mode = 0;
    if (ms && a[19:4] >= (regs[0] & 16'hffc0)) begin
      exp_sel[12] = 0;
      take(regs[0][2:0]);
    end
    if (ms && acc[1] && a[19:4] <= (regs[1] | 16'h003f)) begin
      exp_sel[11] = 0;
      take(regs[1][2:0]);
    end
    if (acc[3] && acc[4]) begin
      n = 0;
      for (int i = 0; i < 7; i++) if (regs[4][8 + i]) n = i;
      tot = 8192 << n;
      base = {regs[3][15:9], 13'h0};
      q = (int'(a) - base) / (tot / 4);
      if (ms && a >= base && a < base + tot) begin
        if (!enhanced_mode || q == 2) exp_sel[7 + q] = 0;
        take(regs[3][2:0]);
      end
    end
    if (acc[2] && acc[4]) begin
      base = {regs[2][15:6], 10'h0};
      q = (int'(a) - base) / 128;
      if (ms == regs[4][6] && a >= base && q < 7 && (q < 5 || regs[4][7])) begin
        exp_sel[q] = 0;
        take(q < 4 ? regs[2][2:0] : regs[4][2:0]);
      end
      if (!regs[4][7]) exp_sel[6:5] = {a[2], a[1]};
    end
  endtask
  task automatic run_cycle(input logic [19:0] a, input bit ms);
    @(negedge core_clk);
    cycle = '{1'b1, ms, a};
    predict(a, ms);
    if ({exp_sel[12:7], exp_sel[4:0]} != 11'h7ff) exp_hits++;
    @(negedge core_clk);
    cycle = '0;
    compare(sel_n, exp_sel, "selects");
    compare(ready_valid, exp_rv, "ready valid");
    if (exp_rv) compare({ignore_external_ready, wait_states, ready_mode_field}, {exp_mode, exp_mode}, "ready");
  endtask
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    regs[0] = 16'hfffb;
    repeat (12) @(negedge core_clk);
    compare({ready_valid, sel_n}, 14'h1fff, "reset selects");
    reset_n = 1;
    reg_op(0, 0, 0);
    run_cycle(20'hfffff, 1);
    run_cycle(20'hffc00, 1);
    run_cycle(20'hffbff, 1);
    run_cycle(20'h00000, 1);
    reg_op(3, 1, 16'h0403);
    run_cycle(20'h02000, 1);
    reg_op(2, 1, 16'h0002);
    run_cycle(20'h00010, 0);
    $display("Test reset state done");
    for (int n = 0; n < 24; n++) begin
      enhanced_mode = n >= 16;
      r = $random(seed);
      k = r[10:8] % 6;
      reg_op(0, 1, (16'hffff << (6 + r[3:0] % 9)) | 16'h0038 | r[6:4]);
      if (n % 3 == 0) reg_op(1, 1, (((16'h0040 << r[15:12] % 9) - 1) & 16'hffc0) | 16'h0038 | r[18:16]);
      reg_op(4, 1, (16'h0100 << k) | {8'h0, r[20:19], 3'h0, r[23:21]});
      reg_op(3, 1, {r[30:24] & ~7'((1 << k) - 1), 6'h0, r[2:0]});
      r = $random(seed);
      reg_op(2, 1, {regs[4][6] ? r[15:12] : 4'h0, r[11:6], 3'h0, r[2:0]});
      for (int i = 0; i < 6; i++) reg_op(i, 0, 0);
      for (int j = 0; j < 20; j++) begin
        r = $random(seed);
        sp = r[20];
        case (r[23:21])
          0, 1: a = {regs[2][15:6], 10'h0} + r[9:0];
          2, 3: a = {regs[3][15:9], 13'h0} + (r[18:0] % (32'h2000 << k));
          4: a = r[19:0] >> 2;
          5: a = 20'hfffff - r[13:0];
          default: a = r[19:0];
        endcase
        if (!sp) a[19:16] = 4'h0;
        run_cycle(a, sp);
      end
    end
    $display("Test random decode done");
    compare(16'(hits), 16'(exp_hits), "partner selected cycles");
    conclude();
  end
  initial begin
    #200us;
    bad_count++;
    conclude();
  end
endmodule
